//--- jkx_cfg.svh
`ifndef JKX_CFG_SVH
`define JKX_CFG_SVH

// three-valued signal codes; the spare code 2'h3 is read as unknown
`define JKX_V0 2'h0
`define JKX_V1 2'h1
`define JKX_VX 2'h2

// initial state select codes
`define JKX_INIT_ZERO 2'h0
`define JKX_INIT_ONE 2'h1
`define JKX_INIT_UNK 2'h2

// reset values
`define JKX_STATE_RST `JKX_VX
`define JKX_SYNC_RST 2'h0

`endif

//--- jkx_pkg.sv
`default_nettype none
package jkx_pkg;
  // two-bit carrier for a 0 / 1 / unknown value
  typedef logic [1:0] jkx_tri_t;
endpackage : jkx_pkg
`default_nettype wire

//--- jkx_next_state.sv
`timescale 1ns/1ps
`default_nettype none
`include "jkx_cfg.svh"
module jkx_next_state (
  input wire jkx_pkg::jkx_tri_t j_i,
  input wire jkx_pkg::jkx_tri_t k_i,
  input wire jkx_pkg::jkx_tri_t old_i,
  output jkx_pkg::jkx_tri_t next_o
);
  import jkx_pkg::*;

  // ****************************************
  // three-valued next-state table
  // ****************************************
  function automatic jkx_tri_t norm(input jkx_tri_t v);
    norm = (v == `JKX_V0 || v == `JKX_V1) ? v : `JKX_VX;
  endfunction : norm

  jkx_tri_t j_n;
  jkx_tri_t k_n;
  jkx_tri_t o_n;

  assign j_n = norm(j_i);
  assign k_n = norm(k_i);
  assign o_n = norm(old_i);

  always_comb begin
    next_o = `JKX_VX;
    case ({j_n, k_n})
      {`JKX_V0, `JKX_V0}: next_o = o_n;
      {`JKX_V0, `JKX_V1}: next_o = `JKX_V0;
      {`JKX_V1, `JKX_V0}: next_o = `JKX_V1;
      {`JKX_V1, `JKX_V1}: begin
        // unknown stays unknown on invert
        if (o_n == `JKX_V0) begin
          next_o = `JKX_V1;
        end else if (o_n == `JKX_V1) begin
          next_o = `JKX_V0;
        end else begin
          next_o = `JKX_VX;
        end
      end
      {`JKX_V0, `JKX_VX}: next_o = (o_n == `JKX_V0) ? `JKX_V0 : `JKX_VX;
      {`JKX_V1, `JKX_VX}: next_o = (o_n == `JKX_V0) ? `JKX_V1 : `JKX_VX;
      {`JKX_VX, `JKX_V0}: next_o = (o_n == `JKX_V1) ? `JKX_V1 : `JKX_VX;
      {`JKX_VX, `JKX_V1}: next_o = (o_n == `JKX_V1) ? `JKX_V0 : `JKX_VX;
      default: next_o = `JKX_VX;
    endcase
  end
endmodule : jkx_next_state
`default_nettype wire

//--- jkx_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "jkx_cfg.svh"
module jkx_top (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire jkx_pkg::jkx_tri_t j_i,
  input wire jkx_pkg::jkx_tri_t k_i,
  input wire logic jk_clk_i,
  input wire logic set_i,
  input wire logic clear_i,
  input wire logic [1:0] initial_state_select_i,
  output jkx_pkg::jkx_tri_t out_o,
  output jkx_pkg::jkx_tri_t out_n_o
);
  import jkx_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= `JKX_SYNC_RST;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ****************************************
  // clock edge detect
  // ****************************************
  logic jk_clk_q;
  logic jk_rise;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      // starting high stops a held-high clock counting as an edge
      jk_clk_q <= 1'b1;
    end else begin
      jk_clk_q <= jk_clk_i;
    end
  end

  assign jk_rise = jk_clk_i && !jk_clk_q;

  // ****************************************
  // stored state
  // ****************************************
  jkx_tri_t state_q;
  jkx_tri_t state_nx;
  logic init_done_q;
  logic forced;

  assign forced = set_i || clear_i;

  jkx_next_state u_next (
    .j_i(j_i),
    .k_i(k_i),
    .old_i(state_q),
    .next_o(state_nx)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= `JKX_STATE_RST;
    end else if (!init_done_q) begin
      // initial state is caught once, after reset release
      case (initial_state_select_i)
        `JKX_INIT_ZERO: state_q <= `JKX_V0;
        `JKX_INIT_ONE: state_q <= `JKX_V1;
        default: state_q <= `JKX_VX;
      endcase
    end else if (set_i && clear_i) begin
      state_q <= `JKX_VX;
    end else if (set_i) begin
      state_q <= `JKX_V1;
    end else if (clear_i) begin
      state_q <= `JKX_V0;
    end else if (jk_rise) begin
      state_q <= state_nx;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // combinational override so set and clear act without waiting for an edge
  always_comb begin
    if (set_i && clear_i) begin
      out_o = `JKX_VX;
    end else if (set_i) begin
      out_o = `JKX_V1;
    end else if (clear_i) begin
      out_o = `JKX_V0;
    end else if (state_q == `JKX_V0 || state_q == `JKX_V1) begin
      out_o = state_q;
    end else begin
      out_o = `JKX_VX;
    end
  end

  always_comb begin
    case (out_o)
      `JKX_V0: out_n_o = `JKX_V1;
      `JKX_V1: out_n_o = `JKX_V0;
      default: out_n_o = `JKX_VX;
    endcase
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  sequence jk_edge_s;
    init_done_q && !forced && jk_rise;
  endsequence

  sequence quiet_s;
    init_done_q && !forced && !jk_rise;
  endsequence

  // two released cycles with no edge, used to see a forced value persist
  sequence hold_two_s;
    quiet_s [*2];
  endsequence

  no_edge_hold_a: assert property (quiet_s |=> $stable(state_q))
    else $error("state moved without a clock edge");

  out_follows_a: assert property (!forced |-> out_o == state_q)
    else $error("output does not follow stored state");

  known_hold_a: assert property (jk_edge_s ##0
      (j_i == `JKX_V0 && k_i == `JKX_V0 && state_q != `JKX_VX) |=> $stable(state_q))
    else $error("hold on edge failed");

  known_set_a: assert property (jk_edge_s ##0 (j_i == `JKX_V1 && k_i == `JKX_V0)
      |=> state_q == `JKX_V1)
    else $error("set on edge failed");

  known_toggle_a: assert property (jk_edge_s ##0 (j_i == `JKX_V1 && k_i == `JKX_V1
      && state_q == `JKX_V0) |=> state_q == `JKX_V1 ##0 (out_n_o == `JKX_V0 || forced))
    else $error("invert from zero failed");

  toggle_one_a: assert property (jk_edge_s ##0 (j_i == `JKX_V1 && k_i == `JKX_V1
      && state_q == `JKX_V1) |=> state_q == `JKX_V0)
    else $error("invert from one failed");

  known_clear_a: assert property (jk_edge_s ##0 (j_i == `JKX_V0 && k_i == `JKX_V1)
      |=> state_q == `JKX_V0)
    else $error("clear on edge failed");

  j0_kx_a: assert property (jk_edge_s ##0 (j_i == `JKX_V0 && k_i == `JKX_VX)
      |=> state_q == ($past(state_q) == `JKX_V0 ? `JKX_V0 : `JKX_VX))
    else $error("j zero k unknown wrong");

  j1_kx_a: assert property (jk_edge_s ##0 (j_i == `JKX_V1 && k_i == `JKX_VX)
      |=> state_q == ($past(state_q) == `JKX_V0 ? `JKX_V1 : `JKX_VX))
    else $error("j one k unknown wrong");

  jx_k0_a: assert property (jk_edge_s ##0 (j_i == `JKX_VX && k_i == `JKX_V0)
      |=> state_q == ($past(state_q) == `JKX_V1 ? `JKX_V1 : `JKX_VX))
    else $error("j unknown k zero wrong");

  jx_k1_a: assert property (jk_edge_s ##0 (j_i == `JKX_VX && k_i == `JKX_V1)
      |=> state_q == ($past(state_q) == `JKX_V1 ? `JKX_V0 : `JKX_VX))
    else $error("j unknown k one wrong");

  both_unknown_a: assert property (jk_edge_s ##0 (j_i == `JKX_VX && k_i == `JKX_VX)
      |=> state_q == `JKX_VX)
    else $error("both unknown not unknown");

  unk_set_a: assert property (jk_edge_s ##0 (state_q == `JKX_VX && j_i == `JKX_V1
      && k_i == `JKX_V0) |=> state_q == `JKX_V1)
    else $error("set from unknown failed");

  unk_clear_a: assert property (jk_edge_s ##0 (state_q == `JKX_VX && j_i == `JKX_V0
      && k_i == `JKX_V1) |=> state_q == `JKX_V0)
    else $error("clear from unknown failed");

  unk_stays_a: assert property (jk_edge_s ##0 (state_q == `JKX_VX && j_i == k_i
      && j_i != `JKX_VX) |=> state_q == `JKX_VX)
    else $error("hold or invert resolved an unknown");

  force_set_a: assert property (init_done_q && set_i && !clear_i |-> out_o == `JKX_V1
      ##1 hold_two_s |-> out_o == `JKX_V1)
    else $error("set not held");

  force_clear_a: assert property (clear_i && !set_i
      |-> out_o == `JKX_V0 && out_n_o == `JKX_V1)
    else $error("clear not shown at once");

  clear_kept_a: assert property (init_done_q && clear_i && !set_i
      ##1 hold_two_s |-> out_o == `JKX_V0)
    else $error("clear not held");

  both_forced_a: assert property (init_done_q && set_i && clear_i
      |-> out_o == `JKX_VX ##1 state_q == `JKX_VX)
    else $error("set with clear not unknown");

  complement_a: assert property ((out_o == `JKX_V0 && out_n_o == `JKX_V1)
      || (out_o == `JKX_V1 && out_n_o == `JKX_V0)
      || (out_o == `JKX_VX && out_n_o == `JKX_VX))
    else $error("inverted output not complement");
endmodule : jkx_top
`default_nettype wire

//--- jkx_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// upstream logic driving j, k and the flip-flop clock
// ****
module jkx_src (
  input wire logic clk_i,
  output var jkx_pkg::jkx_tri_t j_o,
  output var jkx_pkg::jkx_tri_t k_o,
  output var logic jk_clk_o
);
  import jkx_pkg::*;
  initial begin
    j_o = 2'h0;
    k_o = 2'h0;
    jk_clk_o = 1'b0;
  end
  // e=0 presents data with no clock rise; data goes unknown once its hold ends
  task automatic pulse(input jkx_tri_t j, input jkx_tri_t k, input logic e);
    @(posedge clk_i) #1 j_o = j;
    k_o = k;
    @(posedge clk_i) #1 jk_clk_o = e;
    @(posedge clk_i) #1 jk_clk_o = 1'b0;
    j_o = 2'h2;
    k_o = 2'h2;
  endtask : pulse
endmodule : jkx_src
`default_nettype wire

//--- jkx_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import jkx_pkg::*;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic set_i = 1'b0;
  logic clear_i = 1'b0;
  logic [1:0] sel = 2'h1;
  jkx_tri_t j, k, q, qn;
  logic jk_clk;
  int n_errors = 0;
  int compares = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  jkx_src i_jkx_src (.clk_i(ref_clk_i), .j_o(j), .k_o(k), .jk_clk_o(jk_clk));
  jkx_top i_jkx_top (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .j_i(j), .k_i(k),
    .jk_clk_i(jk_clk), .set_i(set_i), .clear_i(clear_i),
    .initial_state_select_i(sel), .out_o(q), .out_n_o(qn));
  // ****
  // checking
  // ****
  function automatic jkx_tri_t nxt(jkx_tri_t jv, jkx_tri_t kv, jkx_tri_t o);
    if (jv < 2 && kv < 2) return (jv != kv) ? jv : (o == 2) ? 2'h2 : jv ? {1'b0, ~o[0]} : o;
    if (jv < 2) return (o == 0) ? jv : 2'h2;
    if (kv < 2) return (o == 1) ? {1'b0, ~kv[0]} : 2'h2;
    return 2'h2;
  endfunction : nxt
  task automatic chk(input string what, input jkx_tri_t seen, input jkx_tri_t exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // both asserted leaves the state unknown
  task automatic set_old(input jkx_tri_t o);
    @(posedge ref_clk_i) #1 set_i = (o != 0);
    clear_i = (o != 1);
    #1 chk("forced", q, o);
    @(posedge ref_clk_i) #1 set_i = 1'b0;
    clear_i = 1'b0;
  endtask : set_old
  task automatic test_table;
    for (int o = 0; o < 3; o++) for (int a = 0; a < 4; a++) for (int b = 0; b < 4; b++) begin
      jkx_tri_t e;
      e = nxt(a[1:0], b[1:0], o[1:0]);
      set_old(o[1:0]);
      i_jkx_src.pulse(a[1:0], b[1:0], 1'b1);
      chk("out", q, e);
      chk("out_n", qn, (e == 2'h2) ? 2'h2 : {1'b0, ~e[0]});
    end
    $display("table test done");
  endtask : test_table
  task automatic test_hold;
    set_old(2'h1);
    i_jkx_src.pulse(2'h0, 2'h1, 1'b0);
    repeat (3) @(posedge ref_clk_i);
    chk("hold", q, 2'h1);
    $display("hold test done");
  endtask : test_hold
  task automatic test_refused;
    @(posedge ref_clk_i) #1 set_i = 1'b1;
    i_jkx_src.pulse(2'h0, 2'h1, 1'b1);
    @(posedge ref_clk_i) #1 set_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk("refused", q, 2'h1);
    $display("refused test done");
  endtask : test_refused
  // mid-run reset; every initial-state code is caught after release
  task automatic test_init;
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk_i) #1 resetn_i = 1'b0;
      sel = s[1:0];
      #1 chk("reset", q, 2'h2);
      repeat (2) @(posedge ref_clk_i);
      #1 resetn_i = 1'b1;
      repeat (2) @(posedge ref_clk_i);
      #1 chk("preload", q, 2'h2);
      @(posedge ref_clk_i);
      #1 chk("initial", q, (s == 0) ? 2'h0 : (s == 1) ? 2'h1 : 2'h2);
    end
    $display("init test done");
  endtask : test_init
  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1 chk("initial", q, 2'h1);
    test_hold();
    test_refused();
    test_table();
    test_init();
    end_sim();
  end
  initial begin
    #20000;
    n_errors++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
